// file: design/prrc_ctrl.sv
// prrc_ctrl: pci read prefetch, retry and credit update control with AHB-Lite registers
// assumes: pci side strobes are one-cycle pulses synchronous to hclk
// What this block does
// - prefetch field 00 gives one cache line for prefetchable plain memory reads.
// - prefetch field 10 gives full prefetch for prefetchable plain memory reads.
// - prefetch field 11 disconnects a plain memory read after the first doubleword.
// - special read bit clear: a retried transaction with changed command gets retry.
// - special read bit set: changed memory read command completes if address and enables match.
// - maximum read byte count limits upstream read requests under full prefetch.
// - byte count codes 000/011/111 give 512; others 128,256,1024,2048,4096.
// - update bit clear sends update every two credits, set every one credit.
// - retry status flag set on expiry, sticky until reset or write one.
// - retry limit field selects no limit, 256, 64K or 2G retries.
// - discard disable bit turns off discard timer, combined with bridge control bit 27.
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ns
module prrc_ctrl (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic [31:0]              hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    input  wire logic                rd_req_valid,
    input  wire prrc_pkg::prrc_req_t rd_req,
    input  wire logic                rd_retry,
    input  wire logic                rd_done,
    input  wire logic                credit_freed,
    input  wire logic                bridge_disc_en,
    output logic                     dec_valid,
    output prrc_pkg::prrc_dec_t      dec,
    output logic                     credit_update,
    output logic                     discard_timer_en,
    output logic                     irq
);
    logic [31:0]         ctrl_q;
    logic                rcs_q;
    logic [1:0]          stat_q;
    logic [1:0]          mask_q;
    logic                wr_q;
    logic [31:0]         wa_q;
    logic [31:0]         hrdata_q;
    logic                hreadyout_q;
    logic                addr_ph;
    logic                wr_ctrl;
    logic                wr_stat;
    logic                wr_mask;
    logic [31:0]         rdmux;
    prrc_pkg::prrc_trk_t trk_q;
    prrc_pkg::prrc_req_t pend_q;
    prrc_pkg::prrc_dec_t dec_d;
    prrc_pkg::prrc_dec_t dec_q;
    logic                dec_valid_q;
    logic                cred_q;
    logic                disc_q;
    logic                irq_q;
    logic                expired;
    logic                cred_upd;
    logic [1:0]          pf_mode;
    logic                sdr;
    logic [2:0]          mrbc;
    logic                is_mr_c;
    logic                is_mr_p;
    logic                same_ab;
    logic                cmd_chg;
    logic                chg_retry;
    logic [1:0]          irq_set;

    // fields of the control word
    assign pf_mode = ctrl_q[prrc_pkg::PF_LSB +: 2];
    assign sdr     = ctrl_q[prrc_pkg::SDR_BIT];
    assign mrbc    = ctrl_q[prrc_pkg::MRBC_LSB +: 3];

    // bus slave: zero wait state, always okay
    assign addr_ph = hsel && htrans[1] && hready;
    assign wr_ctrl = wr_q && (wa_q == prrc_pkg::CTRL_OFF);
    assign wr_stat = wr_q && (wa_q == prrc_pkg::IRQ_STAT_OFF);
    assign wr_mask = wr_q && (wa_q == prrc_pkg::IRQ_MASK_OFF);

    always_comb begin
        rdmux = 32'h0;
        case (haddr)
            prrc_pkg::CTRL_OFF: begin
                rdmux = ctrl_q;
                rdmux[prrc_pkg::RCS_BIT] = rcs_q;
            end
            prrc_pkg::IRQ_STAT_OFF: rdmux = {30'h0, stat_q};
            prrc_pkg::IRQ_MASK_OFF: rdmux = {30'h0, mask_q};
            default:                rdmux = 32'h0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q        <= 1'b0;
            wa_q        <= 32'h0;
            hrdata_q    <= 32'h0;
            hreadyout_q <= 1'b0;
        end else begin
            hreadyout_q <= 1'b1;
            wr_q        <= addr_ph && hwrite;
            if (addr_ph) begin
                wa_q <= haddr;
            end
            if (addr_ph && !hwrite) begin
                hrdata_q <= rdmux;
            end
        end
    end

    assign hrdata    = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp     = 1'b0;

    // control word, writable fields only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= prrc_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= hwdata & prrc_pkg::CTRL_RW_MASK;
        end
    end

    // retry status flag, set wins over write one clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rcs_q <= 1'b0;
        end else if (expired) begin
            rcs_q <= 1'b1;
        end else if (wr_ctrl && hwdata[prrc_pkg::RCS_BIT]) begin
            rcs_q <= 1'b0;
        end
    end

    // interrupt status and mask
    assign irq_set = {chg_retry && rd_req_valid, expired};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_q <= prrc_pkg::IRQ_RESET;
            mask_q <= prrc_pkg::IRQ_RESET;
            irq_q  <= 1'b0;
        end else begin
            stat_q <= irq_set | (stat_q & ~(wr_stat ? hwdata[1:0] : 2'h0));
            if (wr_mask) begin
                mask_q <= hwdata[1:0];
            end
            irq_q <= |(stat_q & mask_q);
        end
    end

    assign irq = irq_q;

    // tracking of the retried transaction
    assign is_mr_c = (rd_req.cmd == prrc_pkg::CMD_MR) || (rd_req.cmd == prrc_pkg::CMD_MRL)
                     || (rd_req.cmd == prrc_pkg::CMD_MRM);
    assign is_mr_p = (pend_q.cmd == prrc_pkg::CMD_MR) || (pend_q.cmd == prrc_pkg::CMD_MRL)
                     || (pend_q.cmd == prrc_pkg::CMD_MRM);
    assign same_ab = (trk_q == prrc_pkg::TRK_PEND) && (rd_req.addr == pend_q.addr)
                     && (rd_req.be == pend_q.be);
    assign cmd_chg = same_ab && (rd_req.cmd != pend_q.cmd);
    assign chg_retry = cmd_chg && !(sdr && is_mr_c && is_mr_p);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trk_q  <= prrc_pkg::TRK_IDLE;
            pend_q <= '0;
        end else begin
            case (trk_q)
                prrc_pkg::TRK_IDLE: begin
                    if (rd_retry && rd_req_valid) begin
                        trk_q  <= prrc_pkg::TRK_PEND;
                        pend_q <= rd_req;
                    end
                end
                prrc_pkg::TRK_PEND: begin
                    if (rd_done) begin
                        trk_q <= prrc_pkg::TRK_IDLE;
                    end else if (rd_retry && rd_req_valid && !same_ab) begin
                        pend_q <= rd_req;
                    end
                end
                default: trk_q <= prrc_pkg::TRK_IDLE;
            endcase
        end
    end

    // decision for each pci read request
    always_comb begin
        dec_d            = '0;
        dec_d.retry      = chg_retry;
        dec_d.accept     = !chg_retry;
        dec_d.pf         = prrc_pkg::PF_NONE;
        if (rd_req.cmd == prrc_pkg::CMD_MR && !chg_retry) begin
            case (pf_mode)
                prrc_pkg::PFM_LINE: begin
                    if (rd_req.pref) begin
                        dec_d.pf = prrc_pkg::PF_LINE;
                    end
                end
                prrc_pkg::PFM_FULL: begin
                    if (rd_req.pref) begin
                        dec_d.pf = prrc_pkg::PF_FULL;
                    end
                end
                prrc_pkg::PFM_DISC: dec_d.disc_first = 1'b1;
                default:            dec_d.pf = prrc_pkg::PF_NONE;
            endcase
        end
        if (dec_d.pf == prrc_pkg::PF_FULL) begin
            case (mrbc)
                3'h1:    dec_d.max_bytes = prrc_pkg::BC_128;
                3'h2:    dec_d.max_bytes = prrc_pkg::BC_256;
                3'h4:    dec_d.max_bytes = prrc_pkg::BC_1024;
                3'h5:    dec_d.max_bytes = prrc_pkg::BC_2048;
                3'h6:    dec_d.max_bytes = prrc_pkg::BC_4096;
                default: dec_d.max_bytes = prrc_pkg::BC_512;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dec_q       <= '0;
            dec_valid_q <= 1'b0;
        end else begin
            dec_valid_q <= rd_req_valid;
            if (rd_req_valid) begin
                dec_q <= dec_d;
            end
        end
    end

    assign dec       = dec_q;
    assign dec_valid = dec_valid_q;

    // retry counting
    prrc_retry_cnt u_retry (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .inc       (rd_retry && rd_req_valid),
        .clr       (rd_done),
        .sel       (ctrl_q[prrc_pkg::RCC_LSB +: 2]),
        .expired_q (expired)
    );

    // credit update pacing
    prrc_credit_cnt #(.W(2)) u_credit (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .freed      (credit_freed),
        .per_update (ctrl_q[prrc_pkg::FCU_BIT] ? prrc_pkg::CRED_PER_ONE
                                               : prrc_pkg::CRED_PER_TWO),
        .update_q   (cred_upd)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cred_q <= 1'b0;
            disc_q <= 1'b0;
        end else begin
            cred_q <= cred_upd;
            disc_q <= !ctrl_q[prrc_pkg::DTD_BIT] && bridge_disc_en;
        end
    end

    assign credit_update    = cred_q;
    assign discard_timer_en = disc_q;

    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_pf_line_mode: assert property (
        rd_req_valid && rd_req.cmd == prrc_pkg::CMD_MR && rd_req.pref && !chg_retry
        && pf_mode == prrc_pkg::PFM_LINE |=> dec_valid && dec.pf == prrc_pkg::PF_LINE)
        else $error("one line prefetch not chosen");

    a_pf_full_mode: assert property (
        rd_req_valid && rd_req.cmd == prrc_pkg::CMD_MR && rd_req.pref && !chg_retry
        && pf_mode == prrc_pkg::PFM_FULL |=> dec.pf == prrc_pkg::PF_FULL && dec.accept)
        else $error("full prefetch not chosen");

    a_disc_first_dw: assert property (
        rd_req_valid && rd_req.cmd == prrc_pkg::CMD_MR && !chg_retry
        && pf_mode == prrc_pkg::PFM_DISC |=> dec.disc_first && dec.pf == prrc_pkg::PF_NONE)
        else $error("first doubleword disconnect missing");

    a_cmd_chg_retry: assert property (
        rd_req_valid && cmd_chg && !sdr |=> dec.retry && !dec.accept ##1 stat_q[1])
        else $error("changed command not retried");

    a_cmd_chg_ok: assert property (
        rd_req_valid && cmd_chg && sdr && is_mr_c && is_mr_p |=> dec.accept && !dec.retry)
        else $error("changed read command refused");

    a_max_bytes: assert property (
        dec_valid && dec.pf != prrc_pkg::PF_FULL |-> dec.max_bytes == 13'h0)
        else $error("byte limit given without full prefetch");

    a_bc_decode: assert property (
        rd_req_valid && rd_req.cmd == prrc_pkg::CMD_MR && rd_req.pref && !chg_retry
        && pf_mode == prrc_pkg::PFM_FULL && mrbc == 3'h7 |=> dec.max_bytes == 13'h0200)
        else $error("byte count code 7 not 512");

    a_credit_pair: assert property (
        !ctrl_q[prrc_pkg::FCU_BIT] && credit_freed && !$past(credit_freed)
        && $past(credit_update) == 1'b0 && u_credit.cnt_q == 2'h0 |-> ##2 !credit_update)
        else $error("update sent after one credit");

    a_credit_single: assert property (
        ctrl_q[prrc_pkg::FCU_BIT] && credit_freed |-> ##2 credit_update)
        else $error("update missing for single credit");

    a_rcs_sticky: assert property (
        rcs_q && !(wr_ctrl && hwdata[prrc_pkg::RCS_BIT]) |=> rcs_q)
        else $error("retry status lost");

    a_rcs_set: assert property (
        expired |=> rcs_q && stat_q[0])
        else $error("expiry not flagged");

    a_no_limit: assert property (
        ctrl_q[prrc_pkg::RCC_LSB +: 2] == prrc_pkg::RCC_NONE [*2] |-> !expired)
        else $error("expiry with no limit");

    a_discard_dis: assert property (
        ctrl_q[prrc_pkg::DTD_BIT] |=> !discard_timer_en)
        else $error("discard timer left on");

    a_irq_level: assert property (
        (stat_q & mask_q) != 2'h0 |=> irq)
        else $error("interrupt not raised");

    c_full_read:  cover property (dec_valid && dec.pf == prrc_pkg::PF_FULL);
    c_chg_retry:  cover property (dec_valid && dec.retry);
    c_expired:    cover property (expired);
    c_cred_upd:   cover property (credit_update ##1 !credit_update);
endmodule : prrc_ctrl

// file: design/prrc_pkg.sv
// prrc_pkg: register map, field layout, codes and types of the read prefetch control
// assumes: one AHB-Lite slave, 32-bit words, one clock domain
package prrc_pkg;
    // register byte addresses
    localparam logic [31:0] CTRL_OFF      = 32'h0000_0040;
    localparam logic [31:0] IRQ_STAT_OFF  = 32'h0000_0048;
    localparam logic [31:0] IRQ_MASK_OFF  = 32'h0000_004c;
    // control word field positions
    localparam int          PF_LSB        = 8;
    localparam int          SDR_BIT       = 10;
    localparam int          MRBC_LSB      = 12;
    localparam int          FCU_BIT       = 15;
    localparam int          RCS_BIT       = 16;
    localparam int          RCC_LSB       = 17;
    localparam int          DTD_BIT       = 19;
    localparam logic [31:0] CTRL_RW_MASK  = 32'h000e_f700;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
    // interrupt status bits
    localparam int          IRQ_EXP_BIT   = 0;
    localparam int          IRQ_CMD_BIT   = 1;
    localparam logic [1:0]  IRQ_RESET     = 2'h0;
    // read prefetch field codes
    localparam logic [1:0]  PFM_LINE      = 2'h0;
    localparam logic [1:0]  PFM_FULL      = 2'h2;
    localparam logic [1:0]  PFM_DISC      = 2'h3;
    // retry limit field codes and thresholds
    localparam logic [1:0]  RCC_NONE      = 2'h0;
    localparam logic [1:0]  RCC_256       = 2'h1;
    localparam logic [1:0]  RCC_64K       = 2'h2;
    localparam logic [31:0] RETRY_256     = 32'h0000_0100;
    localparam logic [31:0] RETRY_64K     = 32'h0001_0000;
    localparam logic [31:0] RETRY_2G      = 32'h8000_0000;
    // credits freed per update
    localparam logic [1:0]  CRED_PER_TWO  = 2'h2;
    localparam logic [1:0]  CRED_PER_ONE  = 2'h1;
    // pci memory read command codes
    localparam logic [3:0]  CMD_MR        = 4'h6;
    localparam logic [3:0]  CMD_MRL       = 4'he;
    localparam logic [3:0]  CMD_MRM       = 4'hc;
    // read request byte limits
    localparam logic [12:0] BC_128        = 13'h0080;
    localparam logic [12:0] BC_256        = 13'h0100;
    localparam logic [12:0] BC_512        = 13'h0200;
    localparam logic [12:0] BC_1024       = 13'h0400;
    localparam logic [12:0] BC_2048       = 13'h0800;
    localparam logic [12:0] BC_4096       = 13'h1000;

    typedef enum logic [1:0] {PF_NONE = 2'h0, PF_LINE = 2'h1, PF_FULL = 2'h2} prrc_pf_t;
    typedef enum logic [1:0] {TRK_IDLE = 2'h1, TRK_PEND = 2'h2} prrc_trk_t;

    typedef struct packed {
        logic [3:0]  cmd;
        logic [31:0] addr;
        logic [3:0]  be;
        logic        pref;
    } prrc_req_t;

    typedef struct packed {
        logic        accept;
        logic        retry;
        prrc_pf_t    pf;
        logic        disc_first;
        logic [12:0] max_bytes;
    } prrc_dec_t;
endpackage : prrc_pkg

// file: design/prrc_retry_cnt.sv
// prrc_retry_cnt: counts successive retries and flags expiry at the chosen limit
// assumes: inc and clr are one-cycle pulses in the hclk domain
`timescale 1ns/1ns
module prrc_retry_cnt (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       inc,
    input  wire logic       clr,
    input  wire logic [1:0] sel,
    output logic            expired_q
);
    logic [31:0] cnt_q;
    logic [31:0] thr;
    logic        hit;

    always_comb begin
        case (sel)
            prrc_pkg::RCC_256: thr = prrc_pkg::RETRY_256;
            prrc_pkg::RCC_64K: thr = prrc_pkg::RETRY_64K;
            default:           thr = prrc_pkg::RETRY_2G;
        endcase
    end

    // never expires with no limit selected
    assign hit = inc && (sel != prrc_pkg::RCC_NONE) && (cnt_q + 32'h1 == thr);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q     <= 32'h0;
            expired_q <= 1'b0;
        end else begin
            expired_q <= hit;
            if (clr || hit) begin
                cnt_q <= 32'h0;
            end else if (inc && cnt_q != 32'hffff_ffff) begin
                cnt_q <= cnt_q + 32'h1;
            end
        end
    end
endmodule : prrc_retry_cnt

// file: design/prrc_credit_cnt.sv
// prrc_credit_cnt: pulses an update once per group of freed credits
// assumes: freed is a one-cycle pulse, one credit per pulse
`timescale 1ns/1ns
module prrc_credit_cnt #(
    parameter int W = 2
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         freed,
    input  wire logic [W-1:0] per_update,
    output logic              update_q
);
    logic [W-1:0] cnt_q;
    logic         full;

    assign full = freed && (cnt_q + W'(1) >= per_update);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q    <= '0;
            update_q <= 1'b0;
        end else begin
            update_q <= full;
            if (full) begin
                cnt_q <= '0;
            end else if (freed) begin
                cnt_q <= cnt_q + W'(1);
            end
        end
    end
endmodule : prrc_credit_cnt

// file: tb/prrc_pci_model.sv
// prrc_pci_model: stand-in for pci masters and the link side, read requests and credits
// assumes: strobes are driven right after a rising hclk edge, one cycle wide
`timescale 1ns/1ns
module prrc_pci_model (
    input  wire logic                hclk,
    input  wire logic                dec_valid,
    input  wire prrc_pkg::prrc_dec_t dec,
    output logic                     rd_req_valid,
    output prrc_pkg::prrc_req_t      rd_req,
    output logic                     rd_retry,
    output logic                     rd_done,
    output logic                     credit_freed
);
    prrc_pkg::prrc_dec_t last_dec;
    logic                got;

    initial begin
        rd_req_valid = 1'b0;
        rd_req       = '0;
        rd_retry     = 1'b0;
        rd_done      = 1'b0;
        credit_freed = 1'b0;
        got          = 1'b0;
    end

    // one request, then catch the decision; request lines scrambled once released
    task automatic req(input logic [3:0] cmd, input logic [31:0] a, input logic rty);
        @(posedge hclk);
        rd_req_valid <= 1'b1;
        rd_req       <= '{cmd: cmd, addr: a, be: 4'hf, pref: 1'b1};
        rd_retry     <= rty;
        @(posedge hclk);
        rd_req_valid <= 1'b0;
        rd_retry     <= 1'b0;
        rd_req       <= ~rd_req;
        got = 1'b0;
        for (int i = 0; i < 4 && !got; i++) begin
            @(posedge hclk);
            if (dec_valid === 1'b1) begin
                got      = 1'b1;
                last_dec = dec;
            end
        end
    endtask : req

    // k 0: pending transaction done, else one credit freed
    task automatic pulse(input int k);
        @(posedge hclk);
        if (k == 0) rd_done <= 1'b1;
        else credit_freed <= 1'b1;
        @(posedge hclk);
        rd_done      <= 1'b0;
        credit_freed <= 1'b0;
    endtask : pulse
endmodule : prrc_pci_model

// file: tb/pci_read_prefetch_retry_control_bench.sv
// pci_read_prefetch_retry_control_bench: register and pci side checks of prrc_ctrl
// assumes: single AHB-Lite master, hready fed back from hreadyout
`timescale 1ns/1ns
module pci_read_prefetch_retry_control_bench;
    logic                hclk, hresetn, hsel, hwrite, bridge_disc_en;
    logic [31:0]         haddr, hwdata, hrdata, q;
    logic [1:0]          htrans;
    logic                hreadyout, hresp, dec_valid, credit_update, discard_timer_en, irq;
    logic                rd_req_valid, rd_retry, rd_done, credit_freed;
    prrc_pkg::prrc_req_t rd_req;
    prrc_pkg::prrc_dec_t dec, d;
    int                  err_count, n_checks, n_upd;

    prrc_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rd_req_valid(rd_req_valid),
        .rd_req(rd_req), .rd_retry(rd_retry), .rd_done(rd_done), .credit_freed(credit_freed),
        .bridge_disc_en(bridge_disc_en), .dec_valid(dec_valid), .dec(dec),
        .credit_update(credit_update), .discard_timer_en(discard_timer_en), .irq(irq));

    prrc_pci_model pm_u (.hclk(hclk), .dec_valid(dec_valid), .dec(dec),
        .rd_req_valid(rd_req_valid), .rd_req(rd_req), .rd_retry(rd_retry),
        .rd_done(rd_done), .credit_freed(credit_freed));

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        if (credit_update === 1'b1) n_upd++;
    end

    task automatic end_sim;
        if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 16) begin
            @(posedge hclk);
            n++;
        end
        if (hreadyout !== 1'b1) begin
            err_count++;
            end_sim();
        end
    endtask : wait_rdy

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        q = hrdata;
        chk("okay resp", 32'(hresp), 32'h0);
    endtask : ahb

    task automatic req(input logic [3:0] cmd, input logic [31:0] a, input logic rty);
        pm_u.req(cmd, a, rty);
        chk("decision seen", 32'(pm_u.got), 32'h1);
        d = pm_u.last_dec;
    endtask : req

    function automatic logic [12:0] bc_exp(input logic [2:0] c);
        case (c)
            3'h1: return prrc_pkg::BC_128;
            3'h2: return prrc_pkg::BC_256;
            3'h4: return prrc_pkg::BC_1024;
            3'h5: return prrc_pkg::BC_2048;
            3'h6: return prrc_pkg::BC_4096;
            default: return prrc_pkg::BC_512;
        endcase
    endfunction : bc_exp

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = '0;
        bridge_disc_en = 1'b0;
        err_count = 0;
        n_checks = 0;
        n_upd = 0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        // reset values, access mask, unmapped place
        ahb(0, prrc_pkg::CTRL_OFF, 0);
        chk("ctrl reset", q, prrc_pkg::CTRL_RESET);
        ahb(1, prrc_pkg::CTRL_OFF, 32'hffff_ffff);
        ahb(0, prrc_pkg::CTRL_OFF, 0);
        chk("ctrl rw", q, prrc_pkg::CTRL_RW_MASK);
        ahb(1, 32'h0000_0050, 32'hffff_ffff);
        ahb(0, 32'h0000_0050, 0);
        chk("unmapped", q, 32'h0);
        // prefetch modes against every byte count code
        for (int m = 0; m < 4; m++) begin
            for (int c = 0; c < 8; c++) begin
                ahb(1, prrc_pkg::CTRL_OFF, (32'(c) << 12) | (32'(m) << 8));
                req(prrc_pkg::CMD_MR, 32'h1000 + 32'(c) * 4, 1'b0);
                chk("accept", 32'(d.accept), 32'h1);
                chk("first dword", 32'(d.disc_first), 32'(m == 3));
                chk("max bytes", 32'(d.max_bytes), m == 2 ? 32'(bc_exp(3'(c))) : 0);
                if (m == 0) chk("pf line", 32'(d.pf), 32'(prrc_pkg::PF_LINE));
                if (m == 1) chk("pf rsvd", 32'(d.pf), 32'(prrc_pkg::PF_NONE));
                if (m == 2) chk("pf full", 32'(d.pf), 32'(prrc_pkg::PF_FULL));
            end
        end
        // changed command after retry, special read off then on
        ahb(1, prrc_pkg::CTRL_OFF, 32'h0);
        req(prrc_pkg::CMD_MR, 32'h2000, 1'b1);
        req(prrc_pkg::CMD_MRL, 32'h2000, 1'b0);
        chk("changed cmd retry", 32'(d.retry), 32'h1);
        ahb(0, prrc_pkg::IRQ_STAT_OFF, 0);
        chk("cmd status", q, 32'h2);
        chk("irq masked", 32'(irq), 32'h0);
        ahb(1, prrc_pkg::IRQ_STAT_OFF, 32'h3);
        pm_u.pulse(0);
        ahb(1, prrc_pkg::CTRL_OFF, 32'h1 << prrc_pkg::SDR_BIT);
        req(prrc_pkg::CMD_MR, 32'h3000, 1'b1);
        req(prrc_pkg::CMD_MRM, 32'h3000, 1'b0);
        chk("changed cmd done", {31'h0, d.retry}, 32'h0);
        chk("changed cmd accept", 32'(d.accept), 32'h1);
        pm_u.pulse(0);
        // credit updates, every two then every one
        for (int f = 0; f < 2; f++) begin
            ahb(1, prrc_pkg::CTRL_OFF, 32'(f) << prrc_pkg::FCU_BIT);
            n_upd = 0;
            for (int i = 0; i < 4; i++) pm_u.pulse(1);
            repeat (4) @(posedge hclk);
            chk("credit updates", 32'(n_upd), f ? 32'h4 : 32'h2);
        end
        // retry limit 256: boundary, expiry, irq, write one to clear
        ahb(1, prrc_pkg::IRQ_MASK_OFF, 32'h1);
        ahb(0, prrc_pkg::IRQ_MASK_OFF, 0);
        chk("irq mask", q, 32'h1);
        ahb(1, prrc_pkg::CTRL_OFF, 32'(prrc_pkg::RCC_256) << prrc_pkg::RCC_LSB);
        for (int i = 0; i < 255; i++) req(prrc_pkg::CMD_MR, 32'h4000, 1'b1);
        ahb(0, prrc_pkg::CTRL_OFF, 0);
        chk("no early expiry", q[16], 1'b0);
        req(prrc_pkg::CMD_MR, 32'h4000, 1'b1);
        repeat (3) @(posedge hclk);
        ahb(0, prrc_pkg::CTRL_OFF, 0);
        chk("expired flag", q[16], 1'b1);
        repeat (2) @(posedge hclk);
        chk("irq raised", 32'(irq), 32'h1);
        ahb(1, prrc_pkg::CTRL_OFF, 32'h1 << prrc_pkg::RCS_BIT);
        ahb(1, prrc_pkg::IRQ_STAT_OFF, 32'h1);
        ahb(0, prrc_pkg::CTRL_OFF, 0);
        chk("flag cleared", q[16], 1'b0);
        repeat (2) @(posedge hclk);
        chk("irq cleared", 32'(irq), 32'h0);
        // no limit never expires
        ahb(1, prrc_pkg::CTRL_OFF, 32'h0);
        for (int i = 0; i < 300; i++) req(prrc_pkg::CMD_MR, 32'h5000, 1'b1);
        repeat (3) @(posedge hclk);
        ahb(0, prrc_pkg::CTRL_OFF, 0);
        chk("no limit", q[16], 1'b0);
        // discard timer enable with outside bit
        for (int i = 0; i < 4; i++) begin
            bridge_disc_en <= i[0];
            ahb(1, prrc_pkg::CTRL_OFF, 32'(i[1]) << prrc_pkg::DTD_BIT);
            repeat (3) @(posedge hclk);
            chk("discard en", 32'(discard_timer_en), 32'(i == 1));
        end
        // mid-run reset brings the control word back
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        ahb(0, prrc_pkg::CTRL_OFF, 0);
        chk("ctrl after reset", q, prrc_pkg::CTRL_RESET);
        chk("discard after reset", 32'(discard_timer_en), 32'h1);
        end_sim();
    end
endmodule : pci_read_prefetch_retry_control_bench
